/* src/rcis_map.svh */
`ifndef RCIS_MAP_SVH
`define RCIS_MAP_SVH
// Bit positions of the two reset flags inside the status register.
`define RCIS_STAT_TO_BIT     4
`define RCIS_STAT_PDF_BIT    5
// Reset-flag register: low-voltage flag position.
`define RCIS_RSTF_LOW_VOLTAGE_RESET_FLAG_BIT   2
// Reset values.
`define RCIS_PORT_RST        8'hff
`define RCIS_PCL_RST         8'h00
`define RCIS_INT_RST         8'h00
`define RCIS_TMR_RST         4'h0
`define RCIS_SP_RST          3'h0
`define RCIS_STAT_LOW_RST    4'h0
// Cycles that a reset pulse to the core is held.
`define RCIS_PULSE_CYC       4
`endif

/* src/rcis_pkg.sv */
package rcis_pkg;
   typedef enum logic [1:0] {
      RCIS_RUN_FAST,
      RCIS_RUN_SLOW,
      RCIS_LP_IDLE,
      RCIS_LP_SLEEP
   } rcis_mode_t;

   typedef enum {
      RCIS_ST_POR,
      RCIS_ST_RUN,
      RCIS_ST_FULL,
      RCIS_ST_WARM
   } rcis_state_t;
endpackage : rcis_pkg

/* src/rcis_pulse.sv */
`timescale 1ns/10ps
`include "rcis_map.svh"
// Stretches a one-cycle request into a fixed-length pulse.
module rcis_pulse #(
   parameter int LEN = `RCIS_PULSE_CYC
) (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic trig_in,
   output logic      pulse_out
);
   logic [7:0] cnt_r;

   if (LEN < 1 || LEN > 255) begin : g_len_chk
      $error("rcis_pulse: LEN out of range");
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_r <= 8'h00;
      end else if (trig_in) begin
         cnt_r <= 8'(LEN);
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   assign pulse_out = (cnt_r != 8'h00);
endmodule : rcis_pulse

/* src/rcis_top.sv */
`timescale 1ns/10ps
`include "rcis_map.svh"
// Functional notes
// - Active-mode watchdog expiry: full reset, set TO.
// - Low-power watchdog expiry clears only PC, SP.
// - Low-power watchdog expiry sets TO and POWER_DOWN_FLAG.
// - Power-on reset clears TO and POWER_DOWN_FLAG.
// - Active-mode low-voltage reset keeps both flags.
// - Power-on reset disables every interrupt.
// - Power-on clears watchdog, time bases; watchdog restarts.
// - Power-on reset switches all timers off.
// - Power-on, active watchdog reset: ports all ones.
// - Power-on: PC zero, SP at stack top.
// - Low-power watchdog expiry keeps others, PC_LOW_BYTE zero.
// - Active watchdog reset: peripherals reload, ACC/table kept.
// - Status pattern fixed per reset type.
// - Genuine low-voltage reset sets flag; software clears.
module rcis_top
   import rcis_pkg::*;
#(
   parameter int PULSE_LEN = `RCIS_PULSE_CYC
) (
   input  wire logic       CLK_IN,
   input  wire logic       RSTN_IN,
   input  wire logic       WDT_EXPIRE_IN,
   input  wire logic       LOW_VOLTAGE_RESET_IN,
   input  wire logic [1:0] MODE_IN,
   input  wire logic       SLEEP_ENTER_IN,
   input  wire logic       CLR_WDT_IN,
   input  wire logic       LOW_VOLTAGE_RESET_FLAG_CLEAR_IN,
   output logic            WDT_EXPIRED_FLAG_OUT,
   output logic            POWER_DOWN_FLAG_OUT,
   output logic            LOW_VOLTAGE_RESET_FLAG_OUT,
   output logic            FULL_RESET_OUT,
   output logic            PC_SP_RESET_OUT,
   output logic            PERIPH_RESET_OUT,
   output logic            KEEP_ACC_TABLE_OUT,
   output logic            CORE_HOLD_OUT,
   output logic [7:0]      PC_LOW_BYTE_OUT,
   output logic [2:0]      STACK_PTR_OUT,
   output logic [7:0]      INT_ENABLE_OUT,
   output logic [3:0]      TIMER_ON_OUT,
   output logic [7:0]      PORT_DATA_OUT,
   output logic [7:0]      PORT_DIR_OUT,
   output logic            WDT_CLEAR_OUT,
   output logic            WDT_RUN_OUT,
   output logic [3:0]      STATUS_LOW_OUT
);
   logic        rst_sync1_r;
   logic        rst_sync2_r;
   logic        rstn;
   rcis_state_t state_r;
   logic        full_trig;
   logic        warm_trig;
   logic        pulse;
   logic        por_done_r;

   // Zero would never hold the core at all, and the pulse counter is only eight bits wide.
   if (PULSE_LEN < 1 || PULSE_LEN > 255) begin : g_len_chk
      $error("rcis_top: PULSE_LEN out of range");
   end

   function automatic logic is_low_power(input logic [1:0] m);
      return (m == RCIS_LP_IDLE) || (m == RCIS_LP_SLEEP);
   endfunction : is_low_power

   // Release goes through two flops so that every flop below leaves reset on one edge.
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end
   assign rstn = rst_sync2_r;

   // The detector disables itself in low power, so a low-voltage event is only
   // honoured while running.
   logic lvr_evt;
   assign lvr_evt = LOW_VOLTAGE_RESET_IN && !is_low_power(MODE_IN);

   // Mode is sampled on the expiry cycle itself.
   assign full_trig = (state_r == RCIS_ST_RUN) &&
                      ((WDT_EXPIRE_IN && !is_low_power(MODE_IN)) || lvr_evt);
   assign warm_trig = (state_r == RCIS_ST_RUN) &&
                      WDT_EXPIRE_IN && is_low_power(MODE_IN);

   rcis_pulse #(
      .LEN(PULSE_LEN)
   ) u_pulse (
      .clk_in   (CLK_IN),
      .rstn_in  (rstn),
      .trig_in  (full_trig || warm_trig || (state_r == RCIS_ST_POR && !por_done_r)),
      .pulse_out(pulse)
   );

   // Marks the first cycle out of reset, which launches the power-on pulse.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         por_done_r <= 1'b0;
      end else begin
         por_done_r <= 1'b1;
      end
   end

   // Events that arrive while a reset sequence still runs start no new sequence on purpose; only the low-voltage flag still records them.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         state_r <= RCIS_ST_POR;
      end else begin
         case (state_r)
            RCIS_ST_POR:  if (por_done_r && !pulse) state_r <= RCIS_ST_RUN;
            RCIS_ST_RUN: begin
               if (full_trig) state_r <= RCIS_ST_FULL;
               else if (warm_trig) state_r <= RCIS_ST_WARM;
            end
            RCIS_ST_FULL: if (!pulse) state_r <= RCIS_ST_RUN;
            RCIS_ST_WARM: if (!pulse) state_r <= RCIS_ST_RUN;
            default:      state_r <= RCIS_ST_POR;
         endcase
      end
   end

   // Status flags.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         WDT_EXPIRED_FLAG_OUT <= 1'b0;
         POWER_DOWN_FLAG_OUT  <= 1'b0;
      end else if (warm_trig) begin
         WDT_EXPIRED_FLAG_OUT <= 1'b1;
         POWER_DOWN_FLAG_OUT  <= 1'b1;
      end else if (full_trig && WDT_EXPIRE_IN) begin
         WDT_EXPIRED_FLAG_OUT <= 1'b1;
      end else if (full_trig) begin
         WDT_EXPIRED_FLAG_OUT <= WDT_EXPIRED_FLAG_OUT;
      end else if (state_r == RCIS_ST_RUN) begin
         if (SLEEP_ENTER_IN) begin
            POWER_DOWN_FLAG_OUT  <= 1'b1;
            WDT_EXPIRED_FLAG_OUT <= 1'b0;
         end else if (CLR_WDT_IN) begin
            POWER_DOWN_FLAG_OUT  <= 1'b0;
            WDT_EXPIRED_FLAG_OUT <= 1'b0;
         end
      end
   end

   // Set wins over a software clear in the same cycle.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         LOW_VOLTAGE_RESET_FLAG_OUT <= 1'b0;
      end else if (lvr_evt) begin
         LOW_VOLTAGE_RESET_FLAG_OUT <= 1'b1;
      end else if (LOW_VOLTAGE_RESET_FLAG_CLEAR_IN) begin
         LOW_VOLTAGE_RESET_FLAG_OUT <= 1'b0;
      end
   end

   // Reset strobes to the core and peripherals.
   // They are registered, which costs one cycle of latency but keeps them glitch free.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         FULL_RESET_OUT     <= 1'b1;
         PC_SP_RESET_OUT    <= 1'b1;
         PERIPH_RESET_OUT   <= 1'b1;
         KEEP_ACC_TABLE_OUT <= 1'b0;
         CORE_HOLD_OUT      <= 1'b1;
      end else begin
         FULL_RESET_OUT     <= full_trig || (state_r == RCIS_ST_FULL && pulse) ||
                               (state_r == RCIS_ST_POR);
         PERIPH_RESET_OUT   <= full_trig || (state_r == RCIS_ST_FULL && pulse) ||
                               (state_r == RCIS_ST_POR);
         PC_SP_RESET_OUT    <= full_trig || warm_trig || (state_r != RCIS_ST_RUN && pulse) ||
                               (state_r == RCIS_ST_POR);
         // Accumulator and table pointers are only lost on power-on.
         KEEP_ACC_TABLE_OUT <= (state_r != RCIS_ST_POR) &&
                               !(state_r == RCIS_ST_RUN && !full_trig && !warm_trig);
         CORE_HOLD_OUT      <= full_trig || warm_trig || (state_r != RCIS_ST_RUN && pulse) ||
                               (state_r == RCIS_ST_POR);
      end
   end

   // Initial architectural state presented to the core.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         PC_LOW_BYTE_OUT <= `RCIS_PCL_RST;
         STACK_PTR_OUT   <= `RCIS_SP_RST;
      end else if (full_trig || warm_trig) begin
         PC_LOW_BYTE_OUT <= `RCIS_PCL_RST;
         STACK_PTR_OUT   <= `RCIS_SP_RST;
      end
   end

   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         INT_ENABLE_OUT <= `RCIS_INT_RST;
         TIMER_ON_OUT   <= `RCIS_TMR_RST;
         PORT_DATA_OUT  <= `RCIS_PORT_RST;
         PORT_DIR_OUT   <= `RCIS_PORT_RST;
         STATUS_LOW_OUT <= `RCIS_STAT_LOW_RST;
      end else if (full_trig) begin
         INT_ENABLE_OUT <= `RCIS_INT_RST;
         TIMER_ON_OUT   <= `RCIS_TMR_RST;
         PORT_DATA_OUT  <= `RCIS_PORT_RST;
         PORT_DIR_OUT   <= `RCIS_PORT_RST;
      end
   end

   // A low-power expiry leaves the watchdog running; the full resets clear it.
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         WDT_CLEAR_OUT <= 1'b1;
         WDT_RUN_OUT   <= 1'b0;
      end else begin
         WDT_CLEAR_OUT <= full_trig || (state_r == RCIS_ST_POR) || CLR_WDT_IN;
         WDT_RUN_OUT   <= 1'b1;
      end
   end
endmodule : rcis_top

/* test/rcis_top_props.sv */
`timescale 1ns/10ps
module rcis_top_props (
   input wire logic       CLK_IN,
   input wire logic       RSTN_IN,
   input wire logic       WDT_EXPIRE_IN,
   input wire logic       LOW_VOLTAGE_RESET_IN,
   input wire logic [1:0] MODE_IN,
   input wire logic       LOW_VOLTAGE_RESET_FLAG_CLEAR_IN,
   input wire logic       CLR_WDT_IN,
   input wire logic       WDT_EXPIRED_FLAG_OUT,
   input wire logic       POWER_DOWN_FLAG_OUT,
   input wire logic       LOW_VOLTAGE_RESET_FLAG_OUT,
   input wire logic       FULL_RESET_OUT,
   input wire logic       PERIPH_RESET_OUT,
   input wire logic       PC_SP_RESET_OUT,
   input wire logic       KEEP_ACC_TABLE_OUT,
   input wire logic       CORE_HOLD_OUT,
   input wire logic [7:0] PC_LOW_BYTE_OUT,
   input wire logic [2:0] STACK_PTR_OUT,
   input wire logic [7:0] INT_ENABLE_OUT,
   input wire logic [3:0] TIMER_ON_OUT,
   input wire logic [7:0] PORT_DATA_OUT,
   input wire logic [7:0] PORT_DIR_OUT,
   input wire logic       WDT_CLEAR_OUT,
   input wire logic       WDT_RUN_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   AST_WDT_ACTIVE: assert property (WDT_EXPIRE_IN && !MODE_IN[1] && !CORE_HOLD_OUT |=>
      WDT_EXPIRED_FLAG_OUT && FULL_RESET_OUT && POWER_DOWN_FLAG_OUT == $past(POWER_DOWN_FLAG_OUT))
      else $error("active watchdog reset wrong");
   AST_WDT_LOWPWR: assert property (WDT_EXPIRE_IN && MODE_IN[1] && !CORE_HOLD_OUT |=>
      WDT_EXPIRED_FLAG_OUT && POWER_DOWN_FLAG_OUT && PC_SP_RESET_OUT && !FULL_RESET_OUT)
      else $error("low power watchdog reset wrong");
   AST_LVR_KEEP: assert property (LOW_VOLTAGE_RESET_IN && !MODE_IN[1] && !CORE_HOLD_OUT |=>
      $stable(WDT_EXPIRED_FLAG_OUT) && $stable(POWER_DOWN_FLAG_OUT) && LOW_VOLTAGE_RESET_FLAG_OUT)
      else $error("low voltage reset flags wrong");
   AST_LOW_VOLTAGE_RESET_FLAG_CLR: assert property (LOW_VOLTAGE_RESET_FLAG_CLEAR_IN && !LOW_VOLTAGE_RESET_IN |=>
      !LOW_VOLTAGE_RESET_FLAG_OUT) else $error("low voltage flag not cleared");
   AST_FULL_INIT: assert property (FULL_RESET_OUT |-> INT_ENABLE_OUT == 8'h00 &&
      TIMER_ON_OUT == 4'h0 && PORT_DATA_OUT == 8'hff && PORT_DIR_OUT == 8'hff)
      else $error("full reset state wrong");
   AST_PC_ZERO: assert property (PC_SP_RESET_OUT |->
      PC_LOW_BYTE_OUT == 8'h00 && STACK_PTR_OUT == 3'h0) else $error("pc or stack not zero");
   AST_WARM_KEEP: assert property (PC_SP_RESET_OUT && !FULL_RESET_OUT |->
      KEEP_ACC_TABLE_OUT) else $error("warm reset does not keep registers");
   AST_WDT_CLEAR: assert property ($rose(FULL_RESET_OUT) |-> WDT_CLEAR_OUT)
      else $error("watchdog not cleared on full reset");
   AST_WDT_RUN: assert property (!CORE_HOLD_OUT |-> WDT_RUN_OUT)
      else $error("watchdog not counting");
   AST_WDT_KEEP: assert property (WDT_EXPIRE_IN && !MODE_IN[1] && !CORE_HOLD_OUT |=>
      PERIPH_RESET_OUT && KEEP_ACC_TABLE_OUT)
      else $error("active watchdog reset keeps the wrong set");
   AST_WARM_PERIPH: assert property (WDT_EXPIRE_IN && MODE_IN[1] && !CORE_HOLD_OUT |=>
      !PERIPH_RESET_OUT && KEEP_ACC_TABLE_OUT)
      else $error("low power watchdog reset hits peripherals");
   AST_WDT_CLR_INSTR: assert property (CLR_WDT_IN |=> WDT_CLEAR_OUT)
      else $error("clear instruction did not clear watchdog");
endmodule : rcis_top_props
bind rcis_top rcis_top_props u_props (.*);

/* test/rcis_core_model.sv */
`timescale 1ns/10ps
// The core only executes its halt and clear instructions while it is running.
module rcis_core_model (
   input  wire logic       hold_in,
   input  wire logic [1:0] req_in,
   output logic            sleep_out,
   output logic            clr_out
);
   assign sleep_out = req_in == 2'h1 && hold_in !== 1'b1;
   assign clr_out   = req_in == 2'h2 && hold_in !== 1'b1;
endmodule : rcis_core_model

/* test/rcis_top_tb_top.sv */
`timescale 1ns/10ps
module rcis_top_tb_top;
   logic CLK_IN = 0, RSTN_IN = 0, WDT_EXPIRE_IN = 0, LOW_VOLTAGE_RESET_IN = 0, LOW_VOLTAGE_RESET_FLAG_CLEAR_IN = 0;
   logic [1:0] MODE_IN = 0, req = 0;
   logic sleep_w, clr_w, hold_w, to_w, pdf_w, lvf_w, run_w;
   logic [7:0] pcl_w, int_w, pd_w, pdir_w;
   logic [3:0] tmr_w, st_w;
   logic [2:0] sp_w;
   int num_errors = 0, tests_run = 0, seed = 82265, eto, epdf, elv, r;
   always #12.5 CLK_IN = ~CLK_IN;
   rcis_core_model core (.hold_in(hold_w), .req_in(req), .sleep_out(sleep_w), .clr_out(clr_w));
   rcis_top uut (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .WDT_EXPIRE_IN(WDT_EXPIRE_IN),
      .LOW_VOLTAGE_RESET_IN(LOW_VOLTAGE_RESET_IN), .MODE_IN(MODE_IN), .SLEEP_ENTER_IN(sleep_w),
      .CLR_WDT_IN(clr_w), .LOW_VOLTAGE_RESET_FLAG_CLEAR_IN(LOW_VOLTAGE_RESET_FLAG_CLEAR_IN), .WDT_EXPIRED_FLAG_OUT(to_w),
      .POWER_DOWN_FLAG_OUT(pdf_w), .LOW_VOLTAGE_RESET_FLAG_OUT(lvf_w), .FULL_RESET_OUT(),
      .PC_SP_RESET_OUT(), .PERIPH_RESET_OUT(), .KEEP_ACC_TABLE_OUT(), .CORE_HOLD_OUT(hold_w),
      .PC_LOW_BYTE_OUT(pcl_w), .STACK_PTR_OUT(sp_w), .INT_ENABLE_OUT(int_w),
      .TIMER_ON_OUT(tmr_w), .PORT_DATA_OUT(pd_w), .PORT_DIR_OUT(pdir_w), .WDT_CLEAR_OUT(),
      .WDT_RUN_OUT(run_w), .STATUS_LOW_OUT(st_w));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task test_done;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Waits out any reset sequence, then compares the three flags with the model.
   task settle;
      int k;
      k = 0;
      repeat (3) @(posedge CLK_IN);
      #1;
      while (hold_w !== 1'b0 && k < 50) begin
         @(posedge CLK_IN);
         #1;
         k++;
      end
      chk("hold", 8'h00, {7'h0, hold_w});
      chk("to", eto[7:0], {7'h0, to_w});
      chk("pdf", epdf[7:0], {7'h0, pdf_w});
      chk("low_voltage_reset_flag", elv[7:0], {7'h0, lvf_w});
   endtask : settle
   task ev(input logic w, input logic l, input logic [1:0] m);
      @(posedge CLK_IN);
      WDT_EXPIRE_IN <= w;
      LOW_VOLTAGE_RESET_IN <= l;
      MODE_IN <= m;
      @(posedge CLK_IN);
      WDT_EXPIRE_IN <= 1'b0;
      LOW_VOLTAGE_RESET_IN <= 1'b0;
      if (w) begin
         eto = 1;
         if (m[1]) epdf = 1;
      end else if (l && !m[1]) elv = 1;
      settle();
   endtask : ev
   // Kind 1 halts, 2 clears the watchdog, 3 clears the low-voltage flag.
   task cmd(input logic [1:0] c);
      @(posedge CLK_IN);
      req <= c;
      LOW_VOLTAGE_RESET_FLAG_CLEAR_IN <= c == 2'h3;
      @(posedge CLK_IN);
      req <= 2'h0;
      LOW_VOLTAGE_RESET_FLAG_CLEAR_IN <= 1'b0;
      if (c == 2'h1) begin epdf = 1; eto = 0; end
      if (c == 2'h2) begin epdf = 0; eto = 0; end
      if (c == 2'h3) elv = 0;
      settle();
   endtask : cmd
   task por;
      @(posedge CLK_IN);
      RSTN_IN <= 1'b0;
      repeat (5) @(posedge CLK_IN);
      RSTN_IN <= 1'b1;
      eto = 0; epdf = 0; elv = 0;
      settle();
      chk("pcl", 8'h00, pcl_w);
      chk("sp", 8'h00, {5'h0, sp_w});
      chk("int", 8'h00, int_w);
      chk("tmr", 8'h00, {4'h0, tmr_w});
      chk("port", 8'hff, pd_w);
      chk("dir", 8'hff, pdir_w);
      chk("run", 8'h01, {7'h0, run_w});
      chk("status", 8'h00, {4'h0, st_w});
   endtask : por
   initial begin
      #500000;
      num_errors++;
      test_done();
   end
   initial begin
      por();
      for (int m = 0; m < 4; m++) begin
         cmd(2'h1);
         ev(1'b1, 1'b0, m[1:0]);
         cmd(2'h2);
      end
      ev(1'b0, 1'b1, 2'h0);
      ev(1'b0, 1'b1, 2'h3);
      cmd(2'h3);
      // A genuine low-voltage event and a software clear on one edge: the set wins.
      @(posedge CLK_IN);
      LOW_VOLTAGE_RESET_IN <= 1'b1;
      LOW_VOLTAGE_RESET_FLAG_CLEAR_IN <= 1'b1;
      MODE_IN <= 2'h0;
      @(posedge CLK_IN);
      LOW_VOLTAGE_RESET_IN <= 1'b0;
      LOW_VOLTAGE_RESET_FLAG_CLEAR_IN <= 1'b0;
      elv = 1;
      settle();
      repeat (30) begin
         r = $random(seed);
         if (r[3]) ev(r[0], !r[0], r[2:1]);
         else cmd(r[5:4]);
      end
      cmd(2'h1);
      por();
      test_done();
   end
endmodule : rcis_top_tb_top
